/* File: occ_top.sv */
// Summary of operation
// - idle-halt bit 1 stops channel in CPU idle; 0 keeps it running.
// - hardware sets fault flag on pwm fault; software writes cannot change it.
// - fault flag used only in pwm-with-fault mode 111.
// - timebase select 1 compares against the third timer.
// - control bits 12 to 5 read zero and ignore writes.
// - pin initial state follows the mode field.
// - interrupt edge follows the mode field; mode 110 raises none.
// - pwm-with-fault mode interrupts on fault pin falling edge.
//
// Purpose: register file and top of the compare channel control block
// Assumes: timer counts arrive from same-clock logic; fault pin is asynchronous
// Notes: fault flag clears when mode leaves 111 (hardware clear)
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module occ_top (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic CPU_IDLE,
   input wire logic [15:0] TIMER2_VALUE,
   input wire logic [15:0] TIMER3_VALUE,
   input wire logic FAULT_INPUT_PIN,
   output logic COMPARE_OUTPUT_PIN,
   output logic COMPARE_OUTPUT_PIN_OE,
   output logic IRQ
);
   occ_pkg::occ_regs_type r_reg, r_next;
   occ_ctrl_if ctl ();
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [1:0] flt_sync_reg;
   logic [1:0] idle_sync_reg;
   logic [15:0] ctrl_word;

   // reset release through two flops
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // pin synchronisers
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         flt_sync_reg <= 2'b11;
         idle_sync_reg <= 2'b00;
      end else begin
         flt_sync_reg <= {flt_sync_reg[0], FAULT_INPUT_PIN};
         idle_sync_reg <= {idle_sync_reg[0], CPU_IDLE};
      end
   end

   // control word view, unimplemented bits zero
   always_comb begin
      ctrl_word = occ_pkg::ZERO16;
      ctrl_word[occ_pkg::IDLE_BIT] = r_reg.idle_halt_select;
      ctrl_word[occ_pkg::FLT_BIT] = r_reg.pwm_fault_flag;
      ctrl_word[occ_pkg::TSEL_BIT] = r_reg.timebase_select;
      ctrl_word[occ_pkg::MODE_LSB +: 3] = r_reg.compare_mode_field;
   end

   // register file next state
   always_comb begin
      r_next = r_reg;
      r_next.rdata = occ_pkg::ZERO16;
      if (WR && ADDR == occ_pkg::CTRL_ADDR) begin
         r_next.idle_halt_select = WDATA[occ_pkg::IDLE_BIT];
         r_next.timebase_select = WDATA[occ_pkg::TSEL_BIT];
         r_next.compare_mode_field = WDATA[occ_pkg::MODE_LSB +: 3];
      end
      if (WR && ADDR == occ_pkg::VAL_ADDR) begin
         r_next.primary_compare_value = WDATA;
      end
      // hardware-only fault flag, set wins
      if (r_next.compare_mode_field != occ_pkg::MODE_PWM_FLT) begin
         r_next.pwm_fault_flag = 1'b0;
      end
      if (ctl.fault_event) begin
         r_next.pwm_fault_flag = 1'b1;
      end
      if (RD) begin
         case (ADDR)
            occ_pkg::CTRL_ADDR: r_next.rdata = ctrl_word;
            occ_pkg::STAT_ADDR: r_next.rdata = {15'h0000, COMPARE_OUTPUT_PIN};
            occ_pkg::VAL_ADDR: r_next.rdata = r_reg.primary_compare_value;
            default: r_next.rdata = occ_pkg::ZERO16;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // settings toward the engine
   assign ctl.compare_mode_field = r_reg.compare_mode_field;
   assign ctl.timebase_select = r_reg.timebase_select;
   assign ctl.primary_compare_value = r_reg.primary_compare_value;
   assign ctl.run = ~(r_reg.idle_halt_select & idle_sync_reg[1]);
   assign RDATA = r_reg.rdata;

   occ_engine u_engine (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .ctl(ctl.engine),
      .timer2_value(TIMER2_VALUE),
      .timer3_value(TIMER3_VALUE),
      .fault_level(flt_sync_reg[1]),
      .pin(COMPARE_OUTPUT_PIN),
      .pin_oe(COMPARE_OUTPUT_PIN_OE),
      .irq(IRQ)
   );

   AST_FLT_SET: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ctl.fault_event |=> r_reg.pwm_fault_flag)
      else $error("fault flag not set");
   AST_FLT_MODE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (r_reg.compare_mode_field != occ_pkg::MODE_PWM_FLT) |-> !r_reg.pwm_fault_flag)
      else $error("fault flag outside fault mode");
   AST_RSVD_ZERO: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (RD && ADDR == occ_pkg::CTRL_ADDR) |=> (RDATA[12:5] == 8'h00))
      else $error("unimplemented bits read nonzero");
   AST_FLT_WRITE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (WR && ADDR == occ_pkg::CTRL_ADDR && !WDATA[occ_pkg::FLT_BIT] && !ctl.fault_event
      && r_reg.pwm_fault_flag && WDATA[occ_pkg::MODE_LSB +: 3] == occ_pkg::MODE_PWM_FLT)
      |=> r_reg.pwm_fault_flag)
      else $error("software cleared fault flag");
   AST_FAULT_IRQ: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (ctl.fault_event && ctl.run) |=> IRQ)
      else $error("fault edge without interrupt");

   // read answers stand for one cycle and carry the control view
   sequence seq_ctrl_read;
      RD && ADDR == occ_pkg::CTRL_ADDR;
   endsequence
   AST_CTRL_READ: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      seq_ctrl_read |=> (RDATA == $past(ctrl_word)))
      else $error("control read data wrong");
   AST_RDATA_IDLE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      !RD |=> (RDATA == occ_pkg::ZERO16))
      else $error("read data outside read cycle");
endmodule

/* File: occ_pkg.sv */
// Purpose: shared constants and types of the compare channel control block
// Assumes: 16-bit control register reached over a plain strobe port
// Notes: offsets and timing values are local choices where none is printed
package occ_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int CMP_W = 16;
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STAT_ADDR = 4'h1;
   localparam logic [3:0] VAL_ADDR = 4'h2;
   localparam int IDLE_BIT = 13;
   localparam int FLT_BIT = 4;
   localparam int TSEL_BIT = 3;
   localparam int MODE_LSB = 0;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_LOW_SHOT = 3'h1;
   localparam logic [2:0] MODE_HIGH_SHOT = 3'h2;
   localparam logic [2:0] MODE_TOGGLE = 3'h3;
   localparam logic [2:0] MODE_DELAY_SHOT = 3'h4;
   localparam logic [2:0] MODE_PULSE = 3'h5;
   localparam logic [2:0] MODE_PWM = 3'h6;
   localparam logic [2:0] MODE_PWM_FLT = 3'h7;

   typedef struct packed {
      logic idle_halt_select;
      logic pwm_fault_flag;
      logic timebase_select;
      logic [2:0] compare_mode_field;
      logic [15:0] primary_compare_value;
      logic [15:0] rdata;
   } occ_regs_type;

   typedef struct packed {
      logic pin;
      logic pin_oe;
      logic irq;
      logic pin_prev;
      logic fault_prev;
      logic started;
      logic [2:0] mode_prev;
   } occ_out_type;
endpackage

/* File: occ_ctrl_if.sv */
// Purpose: carries control settings from the register file to the pin engine
// Assumes: single clock domain
// Notes: mode and timer select are levels
`timescale 1ns/1ps
interface occ_ctrl_if;
   logic [2:0] compare_mode_field;
   logic timebase_select;
   logic run;
   logic [15:0] primary_compare_value;
   logic fault_event;
   modport regs (output compare_mode_field, timebase_select, run, primary_compare_value,
      input fault_event);
   modport engine (input compare_mode_field, timebase_select, run, primary_compare_value,
      output fault_event);
endinterface

/* File: occ_engine.sv */
// Purpose: drives the compare output pin and raises the channel interrupt
// Assumes: timer values and fault level already synchronised
// Notes: compare match is equality with the selected timer
`timescale 1ns/1ps
module occ_engine (
   input wire logic clk,
   input wire logic rst_n,
   occ_ctrl_if.engine ctl,
   input wire logic [15:0] timer2_value,
   input wire logic [15:0] timer3_value,
   input wire logic fault_level,
   output logic pin,
   output logic pin_oe,
   output logic irq
);
   occ_pkg::occ_out_type s_reg, s_next;
   logic [15:0] tb;
   logic match;
   logic rise;
   logic fall;
   logic fresh;

   // time base pick and edge detection
   assign tb = ctl.timebase_select ? timer3_value : timer2_value;
   assign match = (tb == ctl.primary_compare_value);
   assign rise = s_reg.pin & ~s_reg.pin_prev;
   assign fall = ~s_reg.pin & s_reg.pin_prev;
   // a new mode, or the first running cycle, loads the start level
   assign fresh = ~s_reg.started | (ctl.compare_mode_field != s_reg.mode_prev);
   assign ctl.fault_event = (ctl.compare_mode_field == occ_pkg::MODE_PWM_FLT)
      & s_reg.fault_prev & ~fault_level;
   assign pin = s_reg.pin;
   assign pin_oe = s_reg.pin_oe;
   assign irq = s_reg.irq;

   // next state of the pin engine
   always_comb begin
      s_next = s_reg;
      s_next.fault_prev = fault_level;
      s_next.pin_prev = s_reg.pin;
      s_next.irq = 1'b0;
      s_next.mode_prev = ctl.compare_mode_field;
      if (ctl.compare_mode_field == occ_pkg::MODE_OFF) begin
         s_next.pin_oe = 1'b0;
         s_next.started = 1'b0;
      end else if (ctl.run) begin
         s_next.pin_oe = 1'b1;
         if (fresh) begin
            s_next.started = 1'b1;
            case (ctl.compare_mode_field)
               occ_pkg::MODE_HIGH_SHOT: s_next.pin = 1'b1;
               occ_pkg::MODE_TOGGLE: s_next.pin = s_reg.pin;
               occ_pkg::MODE_PWM, occ_pkg::MODE_PWM_FLT:
                  s_next.pin = (ctl.primary_compare_value != occ_pkg::ZERO16);
               default: s_next.pin = 1'b0;
            endcase
         end else if (match) begin
            case (ctl.compare_mode_field)
               occ_pkg::MODE_LOW_SHOT: s_next.pin = 1'b1;
               occ_pkg::MODE_HIGH_SHOT: s_next.pin = 1'b0;
               occ_pkg::MODE_TOGGLE: s_next.pin = ~s_reg.pin;
               default: s_next.pin = ~s_reg.pin;
            endcase
         end
         if (ctl.compare_mode_field == occ_pkg::MODE_PWM_FLT && ctl.fault_event) begin
            s_next.pin = 1'b0;
         end
         // interrupt by mode
         case (ctl.compare_mode_field)
            occ_pkg::MODE_LOW_SHOT: s_next.irq = rise;
            occ_pkg::MODE_HIGH_SHOT, occ_pkg::MODE_DELAY_SHOT, occ_pkg::MODE_PULSE:
               s_next.irq = fall;
            occ_pkg::MODE_TOGGLE: s_next.irq = rise | fall;
            occ_pkg::MODE_PWM_FLT: s_next.irq = ctl.fault_event;
            default: s_next.irq = 1'b0;
         endcase
      end else if (fresh) begin
         // halted across a mode change: reload the start level on resume
         s_next.started = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   AST_PWM_NO_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      (ctl.compare_mode_field == occ_pkg::MODE_PWM) |=> !irq)
      else $error("interrupt raised in plain pwm mode");
   AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctl.run && s_reg.started && ctl.compare_mode_field != occ_pkg::MODE_OFF)
      |=> $stable(pin))
      else $error("pin moved while halted");
   AST_OFF_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      (ctl.compare_mode_field == occ_pkg::MODE_OFF) |=> !pin_oe)
      else $error("pin driven while disabled");
endmodule

/* File: occ_pins_model.sv */
// Purpose: far-side circuit on the fault input pin of the compare channel
// Assumes: fault line carries a pull-up resistor
// Notes: the bench asks for a fault by pulling the line low
`timescale 1ns/1ps
module occ_pins_model (
   input wire logic pull_low,
   output logic fault_pin
);
   // a released line floats up to its pull-up level
   assign fault_pin = pull_low ? 1'b0 : 1'b1;
endmodule

/* File: test_output_compare_control.sv */
// Purpose: self-checking bench of the compare channel control block
// Assumes: timers held away from the compare value while control is written
// Notes: expected pin levels come from an integer model of the modes
`timescale 1ns/1ps
module test_output_compare_control;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic idle = 1'b0;
   logic pull = 1'b0;
   logic [15:0] t2 = 16'h0000;
   logic [15:0] t3 = 16'h0000;
   logic [15:0] rdata, v, r;
   logic flt, pin, oe, irq;
   int fails = 0;
   int n_checks = 0;
   int nirq, mp, af, ex;

   // free-running 40 MHz clock
   always #12.5 clk = ~clk;

   occ_pins_model FAR (.pull_low(pull), .fault_pin(flt));
   occ_top DUT (.REF_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .CPU_IDLE(idle), .TIMER2_VALUE(t2), .TIMER3_VALUE(t3),
      .FAULT_INPUT_PIN(flt), .COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_PIN_OE(oe), .IRQ(irq));

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t level %b expected %b", $time, got, exp);
      end
   endtask
   // timers sit away from the compare value while control is written
   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic rd16(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk16(rdata, exp);
   endtask
   // count interrupt pulses over a window of n cycles
   task automatic cnt_irq(input int n);
      nirq = 0;
      repeat (n) begin
         @(posedge clk);
         #1 if (irq === 1'b1) nirq++;
      end
   endtask
   // one-cycle compare match on the chosen timer, then watch interrupts
   task automatic hit(input logic sel);
      @(posedge clk);
      if (sel) t3 <= v;
      else t2 <= v;
      @(posedge clk);
      t2 <= ~v;
      t3 <= ~v;
      cnt_irq(10);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      #1000000;
      fails++;
      $display("BAD %0t watchdog expired", $time);
      tally_and_finish();
   end

   // main sequence
   initial begin
      r = 16'($urandom(36));
      v = 16'($urandom_range(16'hFFFF, 1));
      t2 = ~v;
      t3 = ~v;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd16(occ_pkg::CTRL_ADDR, 16'h0000);
      wr16(occ_pkg::VAL_ADDR, v);
      rd16(occ_pkg::VAL_ADDR, v);
      wr16(occ_pkg::CTRL_ADDR, (16'($urandom) & 16'h1FE0) | 16'h0006);
      rd16(occ_pkg::CTRL_ADDR, 16'h0006);
      $display("register test done");
      mp = 0;
      for (int m = 1; m < 7; m++) begin
         if (m != 3) mp = (m == 2 || m == 6) ? 1 : 0;
         wr16(occ_pkg::CTRL_ADDR, 16'(m));
         chk1(pin, mp[0]);
         chk1(oe, 1'b1);
         af = (m == 1) ? 1 : (m == 2) ? 0 : 1 - mp;
         ex = (m == 1) ? (af > mp) : (m == 3) ? 1 : (m == 6) ? 0 : (af < mp);
         hit(1'b0);
         chk16(16'(nirq), 16'(ex));
         chk1(pin, af[0]);
         mp = af;
      end
      rd16(occ_pkg::STAT_ADDR, 16'(mp));
      $display("mode test done");
      wr16(occ_pkg::CTRL_ADDR, 16'h000B);
      hit(1'b0);
      chk1(pin, mp[0]);
      hit(1'b1);
      mp = 1 - mp;
      chk1(pin, mp[0]);
      wr16(occ_pkg::CTRL_ADDR, 16'h0003);
      hit(1'b1);
      chk1(pin, mp[0]);
      idle <= 1'b1;
      wr16(occ_pkg::CTRL_ADDR, 16'h2003);
      hit(1'b0);
      chk1(pin, mp[0]);
      wr16(occ_pkg::CTRL_ADDR, 16'h0003);
      hit(1'b0);
      mp = 1 - mp;
      chk1(pin, mp[0]);
      idle <= 1'b0;
      $display("timer and idle test done");
      wr16(occ_pkg::CTRL_ADDR, 16'h0006);
      pull <= 1'b1;
      cnt_irq(10);
      chk16(16'(nirq), 16'h0000);
      rd16(occ_pkg::CTRL_ADDR, 16'h0006);
      pull <= 1'b0;
      wr16(occ_pkg::CTRL_ADDR, 16'h0007);
      chk1(pin, 1'b1);
      pull <= 1'b1;
      cnt_irq(10);
      chk16(16'(nirq), 16'h0001);
      chk1(pin, 1'b0);
      rd16(occ_pkg::CTRL_ADDR, 16'h0017);
      pull <= 1'b0;
      wr16(occ_pkg::CTRL_ADDR, 16'h0007);
      rd16(occ_pkg::CTRL_ADDR, 16'h0017);
      wr16(occ_pkg::CTRL_ADDR, 16'hFFFF);
      rd16(occ_pkg::CTRL_ADDR, 16'h201F);
      wr16(occ_pkg::CTRL_ADDR, 16'h0000);
      rd16(occ_pkg::CTRL_ADDR, 16'h0000);
      chk1(oe, 1'b0);
      $display("fault test done");
      tally_and_finish();
   end
endmodule
